// [bench/remote_peer.sv]
// far-side serial partner: drives the clear-to-send pin and the i/o serial clock
`timescale 1ns/1ns
module remote_peer (
  output logic clear_to_send_input,
  output logic serial_clock_pin
);
  // =====================================================================
  // pin levels at time zero: sending allowed, clock idle low
  initial begin
    clear_to_send_input = 1'b0;
    serial_clock_pin = 1'b0;
  end

  // pause or release the far transmitter at any moment
  task automatic set_cts(input logic level);
    clear_to_send_input = level;
  endtask : set_cts

  // one frame of eight 160 ns clock periods, clock still between frames
  task automatic send_frame();
    #3;
    repeat (8) begin
      serial_clock_pin = 1'b1;
      #80;
      serial_clock_pin = 1'b0;
      #80;
    end
  endtask : send_frame
endmodule : remote_peer

// [bench/tb_top.sv]
// self-checking bench for clear-to-send hold-off and receive interrupt timing
`timescale 1ns/1ns
module tb_top;
  // =====================================================================
  // stimulus, outputs and bookkeeping
  logic core_clk, rst_n, reg_wr, reg_rd, bit_fall, frame_done, tx_ev, rx_mid;
  logic [7:0] reg_addr, rx_word, tx_word, sent_word;
  logic [31:0] reg_wdata, reg_rdata, rdv;
  logic clear_to_send_input, serial_clock_pin, tx_start, tx_interrupt, rx_interrupt, irq;
  int errors, check_count, rx_cnt, tx_cnt, start_cnt;

  serial_cts_rx_irq uut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .clear_to_send_input(clear_to_send_input),
    .serial_clock_pin(serial_clock_pin), .tx_bit_clock_fall(bit_fall), .tx_frame_done(frame_done),
    .tx_irq_event(tx_ev), .tx_start(tx_start), .tx_word(tx_word), .rx_stop_mid(rx_mid),
    .rx_shift_word(rx_word), .rx_interrupt(rx_interrupt), .tx_interrupt(tx_interrupt), .irq(irq));

  remote_peer peer (.clear_to_send_input(clear_to_send_input), .serial_clock_pin(serial_clock_pin));

  // 125 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // count output pulses mid-cycle, a stretched pulse counts twice
  always @(negedge core_clk) begin
    if (rx_interrupt === 1'b1) rx_cnt++;
    if (tx_interrupt === 1'b1) tx_cnt++;
    if (tx_start === 1'b1) begin
      start_cnt++;
      sent_word = tx_word;
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  // one-cycle register write
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr

  // one-cycle register read, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    d = reg_rdata;
  endtask : rd

  // one-cycle pulse: 0 bit clock fall, 1 frame done, 2 tx event, 3 uart frame end
  task automatic pulse(input int which);
    @(posedge core_clk);
    case (which)
      0: bit_fall <= 1'b1;
      1: frame_done <= 1'b1;
      2: tx_ev <= 1'b1;
      default: rx_mid <= 1'b1;
    endcase
    @(posedge core_clk);
    {bit_fall, frame_done, tx_ev, rx_mid} <= 4'h0;
  endtask : pulse

  // bounded wait for the receive interrupt count, then a quiet tail
  task automatic expect_rx(input int n);
    int k;
    k = 0;
    while (rx_cnt < n && k < 40) begin
      @(posedge core_clk);
      k++;
    end
    // a wait that runs out ends the run
    if (rx_cnt < n) begin
      errors++;
      $display("[FAIL] rx interrupt wait expected %0d seen %0d", n, rx_cnt);
      summarize();
    end
    cyc(4);
    chk("rx interrupt count", n, rx_cnt);
  endtask : expect_rx

  task automatic summarize();
    $display("errors=%0d checks=%0d", errors, check_count);
    if (errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : summarize

  // watchdog against a hang
  initial begin
    cyc(20000);
    errors++;
    $display("[FAIL] watchdog expected end seen hang");
    summarize();
  end

  // =====================================================================
  // main sequence
  initial begin
    {rst_n, reg_wr, reg_rd, bit_fall, frame_done, tx_ev, rx_mid} = 7'h00;
    {reg_addr, rx_word, reg_wdata} = 48'h0;
    cyc(6);
    rst_n <= 1'b1;
    rd(serial_cts_rx_irq_pkg::CTRL_OFS, rdv);
    chk("ctrl reset", 32'h0, rdv);
    rd(8'h3c, rdv);
    chk("unmapped read", 32'h0, rdv);
    // flow control off: a high clear-to-send is ignored
    peer.set_cts(1'b1);
    wr(serial_cts_rx_irq_pkg::TX_DATA_OFS, 32'h5a);
    cyc(6);
    pulse(0);
    cyc(3);
    chk("start flow off", 1, start_cnt);
    chk("word flow off", 8'h5a, sent_word);
    pulse(1);
    // flow on and held: word accepted, tx interrupt still on time, no start
    wr(serial_cts_rx_irq_pkg::CTRL_OFS, 32'h1);
    wr(serial_cts_rx_irq_pkg::TX_DATA_OFS, 32'ha5);
    pulse(2);
    pulse(0);
    cyc(3);
    chk("tx interrupt held", 1, tx_cnt);
    chk("no start held", 1, start_cnt);
    rd(serial_cts_rx_irq_pkg::STATUS_OFS, rdv);
    chk("tx pending held", 1, rdv[serial_cts_rx_irq_pkg::ST_TX_PEND_BIT]);
    peer.set_cts(1'b0);
    cyc(6);
    chk("wait for bit clock fall", 1, start_cnt);
    pulse(0);
    cyc(3);
    chk("start after release", 2, start_cnt);
    chk("word after release", 8'ha5, sent_word);
    // clear-to-send raised mid-frame: frame finishes, next one waits
    peer.set_cts(1'b1);
    cyc(6);
    wr(serial_cts_rx_irq_pkg::TX_DATA_OFS, 32'h3c);
    pulse(1);
    pulse(0);
    cyc(3);
    chk("no start after frame", 2, start_cnt);
    peer.set_cts(1'b0);
    cyc(6);
    pulse(0);
    cyc(3);
    chk("start third", 3, start_cnt);
    chk("word third", 8'h3c, sent_word);
    pulse(1);
    // uart double buffer: load, holding word, overrun, move on read
    wr(serial_cts_rx_irq_pkg::CTRL_OFS, 32'h4);
    wr(serial_cts_rx_irq_pkg::IRQ_EN_OFS, 32'h1);
    rx_word <= 8'h11;
    pulse(3);
    expect_rx(1);
    chk("irq level", 1, irq);
    rx_word <= 8'h22;
    pulse(3);
    rx_word <= 8'h33;
    pulse(3);
    cyc(6);
    chk("no interrupt while full", 1, rx_cnt);
    rd(serial_cts_rx_irq_pkg::IRQ_STAT_OFS, rdv);
    chk("rx and overrun status", 2'b11, {rdv[2], rdv[0]});
    rd(serial_cts_rx_irq_pkg::RX_DATA_OFS, rdv);
    chk("first word", 8'h11, rdv[7:0]);
    expect_rx(2);
    rd(serial_cts_rx_irq_pkg::RX_DATA_OFS, rdv);
    chk("moved word", 8'h22, rdv[7:0]);
    wr(serial_cts_rx_irq_pkg::IRQ_CLR_OFS, 32'h7);
    cyc(2);
    chk("irq cleared", 0, irq);
    // i/o mode: single buffer on rising edges, double buffer on falling edges
    for (int e = 1; e >= 0; e--) begin
      wr(serial_cts_rx_irq_pkg::CTRL_OFS, 32'h2 | (e << 4) | ((1 - e) << 2));
      rx_word <= 8'h40 + 8'(e);
      peer.send_frame();
      expect_rx(4 - e);
      rd(serial_cts_rx_irq_pkg::RX_DATA_OFS, rdv);
      chk("io word", 8'h40 + 8'(e), rdv[7:0]);
    end
    // fifo, condition 0 with threshold 2, then condition 1
    wr(serial_cts_rx_irq_pkg::CTRL_OFS, 32'h88);
    rx_word <= 8'h61;
    pulse(3);
    cyc(8);
    chk("fifo level one", 4, rx_cnt);
    pulse(3);
    expect_rx(5);
    rd(serial_cts_rx_irq_pkg::RX_DATA_OFS, rdv);
    cyc(6);
    chk("fifo read below", 5, rx_cnt);
    wr(serial_cts_rx_irq_pkg::CTRL_OFS, 32'h68);
    pulse(3);
    cyc(8);
    chk("cond one push", 5, rx_cnt);
    rd(serial_cts_rx_irq_pkg::RX_DATA_OFS, rdv);
    expect_rx(6);
    wr(serial_cts_rx_irq_pkg::CTRL_OFS, 32'he8);
    rd(serial_cts_rx_irq_pkg::RX_DATA_OFS, rdv);
    cyc(6);
    chk("cond one below", 6, rx_cnt);
    summarize();
  end
endmodule : tb_top

// [core/pin_sync.sv]
// three-stage pin synchroniser that accepts a change once two stages agree
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_stable
);
  // =====================================================================
  // stage flops
  logic [WIDTH-1:0] s1_ff, s2_ff, s3_ff, stable_ff;
  logic [WIDTH-1:0] nxt_stable;

  // accept a bit only while the second and third stages agree
  always_comb begin
    for (int i = 0; i < WIDTH; i++) begin
      nxt_stable[i] = (s2_ff[i] == s3_ff[i]) ? s3_ff[i] : stable_ff[i];
    end
  end

  // register the chain; the first stage feeds only the second
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      stable_ff <= '0;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      stable_ff <= nxt_stable;
    end
  end

  assign pin_stable = stable_ff;
endmodule : pin_sync

// [core/serial_cts_rx_irq.sv]
// clear-to-send transmit hold-off and receive interrupt timing for one channel
`timescale 1ns/1ns
module serial_cts_rx_irq #(
  parameter int DATA_W = serial_cts_rx_irq_pkg::DATA_W_DEF,
  parameter int FIFO_DEPTH = serial_cts_rx_irq_pkg::FIFO_DEPTH_DEF,
  parameter int FRAME_BITS = serial_cts_rx_irq_pkg::FRAME_BITS_DEF
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic clear_to_send_input,
  input wire logic serial_clock_pin,
  input wire logic tx_bit_clock_fall,
  input wire logic tx_frame_done,
  input wire logic tx_irq_event,
  output logic tx_start,
  output logic [DATA_W-1:0] tx_word,
  input wire logic rx_stop_mid,
  input wire logic [DATA_W-1:0] rx_shift_word,
  output logic rx_interrupt,
  output logic tx_interrupt,
  output logic irq
);
  localparam int PTR_W = $clog2(FIFO_DEPTH);
  localparam int LVL_W = $clog2(FIFO_DEPTH + 1);
  localparam int CNT_W = $clog2(FRAME_BITS);

  // =====================================================================
  // parameter checks
  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0 || FIFO_DEPTH > 7) begin : bad_depth
    $error("fifo depth must be a power of two from 2 to 4");
  end
  if (DATA_W < 1 || DATA_W > 8 || FRAME_BITS < 2) begin : bad_width
    $error("data width must be 1 to 8 and frame at least 2 bits");
  end

  // level compare against the programmed threshold
  function automatic logic lvl_hit(input logic [LVL_W-1:0] lvl, input logic [1:0] thr,
                                   input logic ge_mode, input logic on_read);
    if (ge_mode) begin
      lvl_hit = on_read && (lvl >= LVL_W'(thr));
    end else begin
      lvl_hit = (lvl == LVL_W'(thr));
    end
  endfunction : lvl_hit

  // =====================================================================
  // pin synchronisers and serial clock edges
  logic [1:0] pins_stable;
  logic sclk_prev_ff;
  logic cts_hi, sclk_now, sclk_rise, sclk_fall;

  pin_sync #(.WIDTH(2)) u_pin_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin_in({serial_clock_pin, clear_to_send_input}),
    .pin_stable(pins_stable)
  );

  assign cts_hi = pins_stable[0];
  assign sclk_now = pins_stable[1];
  assign sclk_rise = sclk_now && !sclk_prev_ff;
  assign sclk_fall = !sclk_now && sclk_prev_ff;

  // =====================================================================
  // control and interrupt registers
  logic [serial_cts_rx_irq_pkg::CTRL_W-1:0] ctrl_ff, nxt_ctrl;
  logic [serial_cts_rx_irq_pkg::IRQ_W-1:0] irq_stat_ff, nxt_irq_stat, irq_en_ff, nxt_irq_en;
  logic [31:0] rdata_ff, nxt_rdata;
  logic flow_en, io_mode, dbl_buf, fifo_en, edge_sel, cond_sel;
  logic [1:0] thr;
  logic wr_ctrl, wr_en, wr_clr, wr_tx, rd_rx;
  logic rx_ev, ovr_ev;

  assign flow_en = ctrl_ff[serial_cts_rx_irq_pkg::FLOW_EN_BIT];
  assign io_mode = ctrl_ff[serial_cts_rx_irq_pkg::IO_MODE_BIT];
  assign dbl_buf = ctrl_ff[serial_cts_rx_irq_pkg::DBL_BUF_BIT];
  assign fifo_en = ctrl_ff[serial_cts_rx_irq_pkg::FIFO_EN_BIT];
  assign edge_sel = ctrl_ff[serial_cts_rx_irq_pkg::EDGE_SEL_BIT];
  assign cond_sel = ctrl_ff[serial_cts_rx_irq_pkg::COND_SEL_BIT];
  assign thr = ctrl_ff[serial_cts_rx_irq_pkg::THR_LSB +: 2];

  // address decode of strobes
  always_comb begin
    wr_ctrl = 1'b0;
    wr_en = 1'b0;
    wr_clr = 1'b0;
    wr_tx = 1'b0;
    rd_rx = 1'b0;
    if (reg_wr && reg_addr == serial_cts_rx_irq_pkg::CTRL_OFS) begin
      wr_ctrl = 1'b1;
    end else if (reg_wr && reg_addr == serial_cts_rx_irq_pkg::IRQ_EN_OFS) begin
      wr_en = 1'b1;
    end else if (reg_wr && reg_addr == serial_cts_rx_irq_pkg::IRQ_CLR_OFS) begin
      wr_clr = 1'b1;
    end else if (reg_wr && reg_addr == serial_cts_rx_irq_pkg::TX_DATA_OFS) begin
      wr_tx = 1'b1;
    end else if (reg_rd && reg_addr == serial_cts_rx_irq_pkg::RX_DATA_OFS) begin
      rd_rx = 1'b1;
    end
  end

  // =====================================================================
  // transmit hold-off
  logic tx_pend_ff, nxt_tx_pend, tx_busy_ff, nxt_tx_busy, tx_start_ff, nxt_tx_start;
  logic tx_int_ff, nxt_tx_int;
  logic [DATA_W-1:0] tx_buf_ff, nxt_tx_buf, tx_word_ff, nxt_tx_word;
  logic can_start;

  // a frame starts only at a bit clock fall and only while not held off
  assign can_start = tx_pend_ff && !tx_busy_ff && tx_bit_clock_fall && !(flow_en && cts_hi);

  always_comb begin
    nxt_tx_pend = tx_pend_ff;
    nxt_tx_busy = tx_busy_ff;
    nxt_tx_buf = tx_buf_ff;
    nxt_tx_word = tx_word_ff;
    nxt_tx_start = 1'b0;
    nxt_tx_int = tx_irq_event;
    if (tx_frame_done) begin
      nxt_tx_busy = 1'b0; // the frame in progress always completes
    end
    if (can_start) begin
      nxt_tx_start = 1'b1;
      nxt_tx_busy = 1'b1;
      nxt_tx_pend = 1'b0;
      nxt_tx_word = tx_buf_ff;
    end
    if (wr_tx && (!tx_pend_ff || can_start)) begin
      nxt_tx_buf = reg_wdata[DATA_W-1:0]; // word waits here while held
      nxt_tx_pend = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_pend_ff <= 1'b0;
      tx_busy_ff <= 1'b0;
      tx_start_ff <= 1'b0;
      tx_int_ff <= 1'b0;
      tx_buf_ff <= '0;
      tx_word_ff <= '0;
    end else begin
      tx_pend_ff <= nxt_tx_pend;
      tx_busy_ff <= nxt_tx_busy;
      tx_start_ff <= nxt_tx_start;
      tx_int_ff <= nxt_tx_int;
      tx_buf_ff <= nxt_tx_buf;
      tx_word_ff <= nxt_tx_word;
    end
  end

  // =====================================================================
  // receive frame end, buffers and fifo
  logic [CNT_W-1:0] bit_cnt_ff, nxt_bit_cnt;
  logic sel_edge, frame_end;
  logic rb_full_ff, nxt_rb_full, sh_full_ff, nxt_sh_full, rx_int_ff;
  logic [DATA_W-1:0] rb_ff, nxt_rb, sh_ff, nxt_sh;
  logic [DATA_W-1:0] fifo_ff [FIFO_DEPTH];
  logic [DATA_W-1:0] nxt_fifo [FIFO_DEPTH];
  logic [PTR_W-1:0] wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic [LVL_W-1:0] lvl_ff, nxt_lvl;
  logic fifo_push;

  // i/o mode ends a frame on the selected edge of the last bit; uart at stop middle
  assign sel_edge = io_mode && (edge_sel ? sclk_rise : sclk_fall);
  assign frame_end = io_mode ? (sel_edge && bit_cnt_ff == CNT_W'(FRAME_BITS - 1)) : rx_stop_mid;
  assign fifo_push = fifo_en && rb_full_ff && (lvl_ff < LVL_W'(FIFO_DEPTH) || (rd_rx && lvl_ff != '0));

  always_comb begin
    nxt_bit_cnt = bit_cnt_ff;
    if (!io_mode) begin
      nxt_bit_cnt = '0;
    end else if (frame_end) begin
      nxt_bit_cnt = '0;
    end else if (sel_edge) begin
      nxt_bit_cnt = bit_cnt_ff + CNT_W'(1);
    end
    nxt_rb_full = rb_full_ff;
    nxt_rb = rb_ff;
    nxt_sh_full = sh_full_ff;
    nxt_sh = sh_ff;
    nxt_fifo = fifo_ff;
    nxt_wp = wp_ff;
    nxt_rp = rp_ff;
    nxt_lvl = lvl_ff;
    rx_ev = 1'b0;
    ovr_ev = 1'b0;
    // software read of the receive data
    if (rd_rx && fifo_en) begin
      if (lvl_ff != '0) begin
        nxt_rp = rp_ff + PTR_W'(1);
        nxt_lvl = lvl_ff - LVL_W'(1);
        if (lvl_hit(nxt_lvl, thr, cond_sel, 1'b1)) begin
          rx_ev = 1'b1;
        end
      end
    end else if (rd_rx) begin
      nxt_rb_full = 1'b0;
      if (dbl_buf && sh_full_ff) begin
        nxt_rb = sh_ff; // waiting word moves on the read
        nxt_rb_full = 1'b1;
        nxt_sh_full = 1'b0;
        rx_ev = 1'b1;
      end
    end
    // buffer drains into the fifo
    if (fifo_push) begin
      nxt_fifo[wp_ff] = rb_ff;
      nxt_wp = wp_ff + PTR_W'(1);
      nxt_lvl = nxt_lvl + LVL_W'(1);
      nxt_rb_full = 1'b0;
      if (lvl_hit(nxt_lvl, thr, cond_sel, 1'b0)) begin
        rx_ev = 1'b1;
      end
    end
    // completed frame from the shift register
    if (frame_end) begin
      if (!nxt_rb_full) begin
        nxt_rb = rx_shift_word;
        nxt_rb_full = 1'b1;
        if (!fifo_en) begin
          rx_ev = 1'b1;
        end
      end else if (dbl_buf && !nxt_sh_full) begin
        nxt_sh = rx_shift_word;
        nxt_sh_full = 1'b1;
      end else begin
        ovr_ev = 1'b1; // word dropped, no receive interrupt
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_prev_ff <= 1'b0;
      bit_cnt_ff <= '0;
      rb_full_ff <= 1'b0;
      sh_full_ff <= 1'b0;
      rb_ff <= '0;
      sh_ff <= '0;
      for (int i = 0; i < FIFO_DEPTH; i++) begin
        fifo_ff[i] <= '0;
      end
      wp_ff <= '0;
      rp_ff <= '0;
      lvl_ff <= '0;
      rx_int_ff <= 1'b0;
    end else begin
      sclk_prev_ff <= sclk_now;
      bit_cnt_ff <= nxt_bit_cnt;
      rb_full_ff <= nxt_rb_full;
      sh_full_ff <= nxt_sh_full;
      rb_ff <= nxt_rb;
      sh_ff <= nxt_sh;
      fifo_ff <= nxt_fifo;
      wp_ff <= nxt_wp;
      rp_ff <= nxt_rp;
      lvl_ff <= nxt_lvl;
      rx_int_ff <= rx_ev; // one-cycle pulse per event
    end
  end

  // =====================================================================
  // register file and sticky interrupt status
  always_comb begin
    nxt_ctrl = wr_ctrl ? reg_wdata[serial_cts_rx_irq_pkg::CTRL_W-1:0] : ctrl_ff;
    nxt_irq_en = wr_en ? reg_wdata[serial_cts_rx_irq_pkg::IRQ_W-1:0] : irq_en_ff;
    nxt_irq_stat = irq_stat_ff;
    if (wr_clr) begin
      nxt_irq_stat = irq_stat_ff & ~reg_wdata[serial_cts_rx_irq_pkg::IRQ_W-1:0];
    end
    // a new event wins over a clear in the same cycle
    nxt_irq_stat[serial_cts_rx_irq_pkg::IRQ_RX_BIT] = nxt_irq_stat[serial_cts_rx_irq_pkg::IRQ_RX_BIT] | rx_ev;
    nxt_irq_stat[serial_cts_rx_irq_pkg::IRQ_TX_BIT] = nxt_irq_stat[serial_cts_rx_irq_pkg::IRQ_TX_BIT] | tx_irq_event;
    nxt_irq_stat[serial_cts_rx_irq_pkg::IRQ_OVR_BIT] = nxt_irq_stat[serial_cts_rx_irq_pkg::IRQ_OVR_BIT] | ovr_ev;
    nxt_rdata = 32'h0000_0000;
    if (reg_rd && reg_addr == serial_cts_rx_irq_pkg::CTRL_OFS) begin
      nxt_rdata[serial_cts_rx_irq_pkg::CTRL_W-1:0] = ctrl_ff;
    end else if (reg_rd && reg_addr == serial_cts_rx_irq_pkg::STATUS_OFS) begin
      nxt_rdata[serial_cts_rx_irq_pkg::ST_RB_FULL_BIT] = rb_full_ff;
      nxt_rdata[serial_cts_rx_irq_pkg::ST_SH_FULL_BIT] = sh_full_ff;
      nxt_rdata[serial_cts_rx_irq_pkg::ST_TX_PEND_BIT] = tx_pend_ff;
      nxt_rdata[serial_cts_rx_irq_pkg::ST_TX_BUSY_BIT] = tx_busy_ff;
      nxt_rdata[serial_cts_rx_irq_pkg::ST_CTS_BIT] = cts_hi;
      nxt_rdata[serial_cts_rx_irq_pkg::ST_LVL_LSB +: LVL_W] = lvl_ff;
    end else if (reg_rd && reg_addr == serial_cts_rx_irq_pkg::IRQ_STAT_OFS) begin
      nxt_rdata[serial_cts_rx_irq_pkg::IRQ_W-1:0] = irq_stat_ff;
    end else if (reg_rd && reg_addr == serial_cts_rx_irq_pkg::IRQ_EN_OFS) begin
      nxt_rdata[serial_cts_rx_irq_pkg::IRQ_W-1:0] = irq_en_ff;
    end else if (rd_rx) begin
      nxt_rdata[DATA_W-1:0] = fifo_en ? fifo_ff[rp_ff] : rb_ff;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff <= serial_cts_rx_irq_pkg::CTRL_RST;
      irq_en_ff <= serial_cts_rx_irq_pkg::IRQ_RST;
      irq_stat_ff <= serial_cts_rx_irq_pkg::IRQ_RST;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ctrl_ff <= nxt_ctrl;
      irq_en_ff <= nxt_irq_en;
      irq_stat_ff <= nxt_irq_stat;
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;
  assign irq = |(irq_stat_ff & irq_en_ff);
  assign tx_start = tx_start_ff;
  assign tx_word = tx_word_ff;
  assign tx_interrupt = tx_int_ff;
  assign rx_interrupt = rx_int_ff;

  // =====================================================================
  // assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  sequence tx_held_s;
    flow_en && cts_hi && tx_pend_ff && !tx_busy_ff;
  endsequence
  sequence tx_free_s;
    tx_pend_ff && !tx_busy_ff && tx_bit_clock_fall && !flow_en;
  endsequence

  held_no_start_a: assert property (tx_held_s |=> !tx_start)
    else $error("frame started while clear-to-send held");
  flow_off_start_a: assert property (tx_free_s |=> tx_start && tx_word == $past(tx_buf_ff))
    else $error("flow control off but frame not started");
  start_on_fall_a: assert property (tx_start |-> $past(tx_bit_clock_fall) && !$past(tx_busy_ff) && tx_busy_ff)
    else $error("frame start not on bit clock fall");
  tx_irq_pass_a: assert property (tx_irq_event |=> tx_interrupt)
    else $error("transmit interrupt lost");
  accept_held_a: assert property (wr_tx && !tx_pend_ff |=> tx_pend_ff && tx_buf_ff == $past(reg_wdata[DATA_W-1:0]))
    else $error("transmit word not accepted while held");
  io_single_irq_a: assert property (frame_end && io_mode && !dbl_buf && !fifo_en && !rb_full_ff && !rd_rx
                                    |=> rx_interrupt && rb_full_ff)
    else $error("single buffer receive interrupt missing");
  dbl_move_irq_a: assert property (frame_end && dbl_buf && !fifo_en && !rb_full_ff && !rd_rx
                                   |=> rx_interrupt && rb_ff == $past(rx_shift_word))
    else $error("double buffer move without interrupt");
  read_move_a: assert property (rd_rx && dbl_buf && !fifo_en && sh_full_ff
                                |=> rx_interrupt && rb_full_ff && rb_ff == $past(sh_ff))
    else $error("read did not move waiting word");
  overrun_quiet_a: assert property (frame_end && dbl_buf && !fifo_en && rb_full_ff && sh_full_ff && !rd_rx
                                    |=> !rx_interrupt ##0 irq_stat_ff[serial_cts_rx_irq_pkg::IRQ_OVR_BIT])
    else $error("receive interrupt raised on overrun");
  fifo_eq_a: assert property (fifo_push && !rd_rx && !cond_sel && lvl_ff + LVL_W'(1) == LVL_W'(thr)
                              |=> rx_interrupt)
    else $error("fifo level match without interrupt");
  fifo_ge_a: assert property (rd_rx && fifo_en && cond_sel && !fifo_push && lvl_ff > LVL_W'(thr)
                              |=> rx_interrupt)
    else $error("fifo read above threshold without interrupt");
  start_pulse_a: assert property (tx_start |=> !tx_start)
    else $error("frame start longer than one cycle");
endmodule : serial_cts_rx_irq

// [include/serial_cts_rx_irq_pkg.sv]
// constants for the clear-to-send flow control and receive interrupt block
// =====================================================================
// Functional notes
// - flow control enable bit gates clear-to-send
// - clear-to-send high: finish frame, start none
// - transmit interrupt and buffer write continue while held
// - pending frame starts on next bit clock fall
// - i/o single buffer: interrupt after last edge
// - double buffer: interrupt on shift-to-buffer move
// - i/o double buffer: interrupt after last edge
// - both full: move and interrupt on read
// - no receive interrupt on overrun frame
// - fifo select 0: interrupt when level equals threshold
// - fifo select 1: interrupt on read, level >= threshold
package serial_cts_rx_irq_pkg;
  // =====================================================================
  // register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] IRQ_EN_OFS = 8'h0c;
  localparam logic [7:0] IRQ_CLR_OFS = 8'h10;
  localparam logic [7:0] TX_DATA_OFS = 8'h14;
  localparam logic [7:0] RX_DATA_OFS = 8'h18;
  // =====================================================================
  // control register fields
  localparam int FLOW_EN_BIT = 0;
  localparam int IO_MODE_BIT = 1;
  localparam int DBL_BUF_BIT = 2;
  localparam int FIFO_EN_BIT = 3;
  localparam int EDGE_SEL_BIT = 4;
  localparam int COND_SEL_BIT = 5;
  localparam int THR_LSB = 6;
  localparam int CTRL_W = 8;
  localparam logic [7:0] CTRL_RST = 8'h00;
  // =====================================================================
  // status register fields
  localparam int ST_RB_FULL_BIT = 0;
  localparam int ST_SH_FULL_BIT = 1;
  localparam int ST_TX_PEND_BIT = 2;
  localparam int ST_TX_BUSY_BIT = 3;
  localparam int ST_CTS_BIT = 4;
  localparam int ST_LVL_LSB = 8;
  // =====================================================================
  // interrupt status bits
  localparam int IRQ_RX_BIT = 0;
  localparam int IRQ_TX_BIT = 1;
  localparam int IRQ_OVR_BIT = 2;
  localparam int IRQ_W = 3;
  localparam logic [2:0] IRQ_RST = 3'h0;
  // =====================================================================
  // reset values and counts
  localparam logic [7:0] WORD_RST = 8'h00;
  localparam int FRAME_BITS_DEF = 8;
  localparam int FIFO_DEPTH_DEF = 4;
  localparam int DATA_W_DEF = 8;
  localparam int SYNC_STAGES = 3;
endpackage : serial_cts_rx_irq_pkg
